// ==== rtl/bus_ctl_params.svh ====
// Purpose: constants for the external bus fault, halt and arbitration block
// Assumes: one clock, synchronous active-high reset
// Notes:   definitions only
`ifndef BUS_CTL_PARAMS_SVH
`define BUS_CTL_PARAMS_SVH
`define SHOW_FIELD_RESET      2'h0
`define SHOW_OFF              2'h0
`define SHOW_ON_RUN           2'h1
`define SHOW_ON_SUSPEND       2'h2
`define PRECHARGE_WORD        16'hFFFF
`define GRANT_NEGATE_CYCLES   3'h2
`define GRANT_REASSERT_CYCLES 3'h2
`define RESET_SYNC_STAGES     2
`endif

// ==== rtl/bus_ctl_pkg.sv ====
// Purpose: types for the external bus fault, halt and arbitration block
// Assumes: constants live in bus_ctl_params.svh
// Notes:   one-hot state codes
package bus_ctl_pkg;
  typedef enum logic [4:0] {
    ARB_IDLE    = 5'h01,
    ARB_WAIT    = 5'h02,
    ARB_GRANT   = 5'h04,
    ARB_OWNED   = 5'h08,
    ARB_RELEASE = 5'h10
  } arb_state_type;
  typedef enum logic [3:0] {
    RUN_NORMAL   = 4'h1,
    RUN_EXCEPT   = 4'h2,
    RUN_POSTRST  = 4'h4,
    RUN_DBLFAULT = 4'h8
  } run_state_type;
endpackage : bus_ctl_pkg

// ==== rtl/bus_sync2.sv ====
// Purpose: two flip-flop synchroniser for pin inputs
// Assumes: input is asynchronous to CLK
// Notes:   first stage read only by the second
`timescale 1ns/100ps
module bus_sync2 #(
  parameter int      WIDTH = 1,
  parameter logic [WIDTH-1:0] INIT = '0
) (
  input  wire logic             CLK,
  input  wire logic             RST,
  input  wire logic [WIDTH-1:0] d,
  output logic      [WIDTH-1:0] q
);
  logic [WIDTH-1:0] meta_r;
  logic [WIDTH-1:0] meta_nxt;
  logic [WIDTH-1:0] q_nxt;

  always_comb begin
    meta_nxt = d;
    q_nxt    = meta_r;
  end

  always_ff @(posedge CLK) begin
    if (RST) begin
      meta_r <= INIT;
      q      <= INIT;
    end else begin
      meta_r <= meta_nxt;
      q      <= q_nxt;
    end
  end
endmodule : bus_sync2

// ==== rtl/ext_bus_fault_halt_arbitration.sv ====
// Purpose: bus error capture, double fault halt, external halt, arbitration, show cycles
// Assumes: CPU and bus sequencer supply cycle and instruction events on CLK
// Notes:   pins active low are named _N; all outputs registered
//
// Functional notes
// - Bus error captured only at cycle end
// - Errored prefetch returns precharge ones, other errored reads keep old data, no capture
// - Error flag held until handler's first instruction
// - Second error during exception entry: double fault
// - Error before first post-reset instruction: double fault
// - Many errors in one instruction, one exception
// - Double fault halts, drives halt low, reset only
// - Arbitration works running, halted, double faulted
// - Errors after exception entry are ordinary
// - Halt stops external bus after acknowledge negates
// - Halt gates external cycles only; single stepping
// - Halted: data floats, strobes off, address held
// - Granted while halted floats; regained restores values
// - Request, grant, acknowledge order; device yields
// - Grant drops after acknowledge change, reasserts if pending
// - Show field resets zero; off hides strobes, data
// - Show on: data strobe and internal data driven
// - One show encoding suspends internal cycles when granted
// - Size shows valid lanes; external byte replicated
// - Reset synchronised, delayed until write completes
`timescale 1ns/100ps
`include "bus_ctl_params.svh"
module ext_bus_fault_halt_arbitration (
  input  wire logic        CLK,
  input  wire logic        RST,
  input  wire logic        RESET_PIN_N,
  input  wire logic        BUS_REQUEST_N,
  input  wire logic        GRANT_ACKNOWLEDGE_N,
  input  wire logic        BUS_ERROR_IN_N,
  input  wire logic        HALT_IN_N,
  input  wire logic        TRANSFER_ACK_N,
  input  wire logic        CYCLE_ACTIVE,
  input  wire logic        CYCLE_END,
  input  wire logic        CYCLE_INTERNAL,
  input  wire logic        CYCLE_WRITE,
  input  wire logic        CYCLE_PREFETCH,
  input  wire logic        OPERAND_DONE,
  input  wire logic        WRITE_PENDING,
  input  wire logic        INSTR_DONE,
  input  wire logic        HANDLER_FIRST,
  input  wire logic        FIRST_AFTER_RESET,
  input  wire logic [23:0] CYCLE_ADDR,
  input  wire logic [2:0]  CYCLE_FC,
  input  wire logic [1:0]  CYCLE_SIZE,
  input  wire logic [15:0] CYCLE_WDATA,
  input  wire logic [15:0] DATA_PIN_IN,
  input  wire logic [1:0]  SHOW_FIELD_WDATA,
  input  wire logic        SHOW_FIELD_WE,
  output logic             BUS_GRANT_N,
  output logic             HALT_OUT_N,
  output logic             HALT_OUT_OE,
  output logic [23:0]      ADDR_OUT,
  output logic [2:0]       FC_OUT,
  output logic [1:0]       TRANSFER_SIZE_OUT,
  output logic             RW_OUT,
  output logic             CTRL_OE,
  output logic             ADDRESS_STROBE_N,
  output logic             DATA_STROBE_N,
  output logic [15:0]      DATA_OUT,
  output logic             DATA_OE,
  output logic [15:0]      READ_DATA,
  output logic             READ_VALID,
  output logic             BUS_ERROR_IN_EXCEPTION,
  output logic             DOUBLE_FAULT,
  output logic             EXT_STALL,
  output logic             INT_STALL,
  output logic             IRQ_BLOCK,
  output logic             CORE_RESET
);
  import bus_ctl_pkg::*;

  logic [4:0] pins_sync;
  logic       req_s, gack_s, bus_error_in_s, halt_s, tack_s;
  logic       rst_pin_s;

  bus_sync2 #(.WIDTH(5), .INIT(5'h1F)) u_pin_sync (
    .CLK (CLK),
    .RST (RST),
    .d   ({BUS_REQUEST_N, GRANT_ACKNOWLEDGE_N, BUS_ERROR_IN_N, HALT_IN_N, TRANSFER_ACK_N}),
    .q   (pins_sync)
  );
  bus_sync2 #(.WIDTH(1), .INIT(1'h0)) u_rst_sync (
    .CLK (CLK),
    .RST (RST),
    .d   (RESET_PIN_N),
    .q   (rst_pin_s)
  );
  assign req_s  = ~pins_sync[4];
  assign gack_s = ~pins_sync[3];
  assign bus_error_in_s = ~pins_sync[2];
  assign halt_s = ~pins_sync[1];
  assign tack_s = ~pins_sync[0];

  // Byte lanes: external byte writes repeat the byte on both lanes
  function automatic logic [15:0] lane_data(input logic [1:0] sz, input logic [15:0] d,
                                            input logic internal);
    lane_data = (sz == 2'h1 && !internal) ? {d[7:0], d[7:0]} : d;
  endfunction : lane_data

  // Core reset: asserted only with pin low and no write pending, released when pin goes high
  logic core_rst_r, core_rst_nxt;
  always_comb begin
    core_rst_nxt = core_rst_r;
    if (!rst_pin_s && !WRITE_PENDING)
      core_rst_nxt = 1'b1;
    else if (rst_pin_s)
      core_rst_nxt = 1'b0;
  end

  // Fault tracking
  run_state_type run_r, run_nxt;
  logic bus_error_in_latch_r, bus_error_in_latch_nxt;
  logic bus_error_in_exc_r, bus_error_in_exc_nxt;
  logic cyc_err_r, cyc_err_nxt;
  logic [15:0] rdata_r, rdata_nxt;
  logic rvalid_r, rvalid_nxt;
  logic end_err;

  always_comb begin
    run_nxt        = run_r;
    bus_error_in_latch_nxt = bus_error_in_latch_r;
    bus_error_in_exc_nxt   = 1'b0;
    cyc_err_nxt    = cyc_err_r;
    rdata_nxt      = rdata_r;
    rvalid_nxt     = 1'b0;
    end_err        = 1'b0;
    // Error remembered within the cycle, acted on only at its end
    if (CYCLE_ACTIVE && bus_error_in_s)
      cyc_err_nxt = 1'b1;
    if (CYCLE_END) begin
      end_err     = cyc_err_r | bus_error_in_s;
      cyc_err_nxt = 1'b0;
      if (!CYCLE_WRITE) begin
        rvalid_nxt = 1'b1;
        if (end_err)
          rdata_nxt = CYCLE_PREFETCH ? `PRECHARGE_WORD : rdata_r;
        else
          rdata_nxt = DATA_PIN_IN;
      end
    end
    unique case (run_r)
      RUN_NORMAL: begin
        if (end_err)
          bus_error_in_latch_nxt = 1'b1;
        if (INSTR_DONE && (bus_error_in_latch_r || end_err)) begin
          run_nxt      = RUN_EXCEPT;
          bus_error_in_exc_nxt = 1'b1;
        end
      end
      RUN_EXCEPT: begin
        if (end_err)
          run_nxt = RUN_DBLFAULT;
        else if (HANDLER_FIRST) begin
          bus_error_in_latch_nxt = 1'b0;
          run_nxt        = RUN_NORMAL;
        end
      end
      RUN_POSTRST: begin
        if (end_err)
          run_nxt = RUN_DBLFAULT;
        else if (FIRST_AFTER_RESET)
          run_nxt = RUN_NORMAL;
      end
      RUN_DBLFAULT: begin
        run_nxt = RUN_DBLFAULT;
      end
    endcase
  end

  // Arbitration
  arb_state_type arb_r, arb_nxt;
  logic [2:0] arb_cnt_r, arb_cnt_nxt;
  logic grant_r, grant_nxt;
  logic granted_r, granted_nxt;

  always_comb begin
    arb_nxt     = arb_r;
    arb_cnt_nxt = (arb_cnt_r != 3'h0) ? arb_cnt_r - 3'h1 : 3'h0;
    grant_nxt   = grant_r;
    granted_nxt = gack_s;
    // Runs in every run state, double fault included
    unique case (arb_r)
      ARB_IDLE: begin
        if (req_s)
          arb_nxt = ARB_WAIT;
      end
      ARB_WAIT: begin
        if (!req_s)
          arb_nxt = ARB_IDLE;
        else if (!CYCLE_ACTIVE || OPERAND_DONE) begin
          arb_nxt   = ARB_GRANT;
          grant_nxt = 1'b1;
        end
      end
      ARB_GRANT: begin
        if (gack_s) begin
          arb_nxt     = ARB_OWNED;
          arb_cnt_nxt = `GRANT_NEGATE_CYCLES;
        end else if (!req_s) begin
          arb_nxt   = ARB_IDLE;
          grant_nxt = 1'b0;
        end
      end
      ARB_OWNED: begin
        if (arb_cnt_r == 3'h0 && grant_r) begin
          grant_nxt   = 1'b0;
          arb_cnt_nxt = `GRANT_REASSERT_CYCLES;
        end else if (!grant_r && req_s && arb_cnt_r == 3'h0)
          grant_nxt = 1'b1;
        if (!gack_s) begin
          arb_nxt     = ARB_RELEASE;
          arb_cnt_nxt = `GRANT_NEGATE_CYCLES;
        end
      end
      ARB_RELEASE: begin
        if (arb_cnt_r == 3'h0) begin
          if (grant_r && gack_s)
            arb_nxt = ARB_OWNED;
          else if (grant_r)
            arb_nxt = ARB_GRANT;
          else
            arb_nxt = req_s ? ARB_WAIT : ARB_IDLE;
        end
      end
    endcase
  end

  // Show field and pin drive
  logic [1:0]  show_r, show_nxt;
  logic        halted_r, halted_nxt;
  logic [23:0] addr_r, addr_nxt;
  logic [2:0]  fc_r, fc_nxt;
  logic [1:0]  siz_r, siz_nxt;
  logic        rw_r, rw_nxt;
  logic        as_r, as_nxt, ds_r, ds_nxt;
  logic [15:0] dout_r, dout_nxt;
  logic        doe_r, doe_nxt, coe_r, coe_nxt;
  logic        ext_stall_r, ext_stall_nxt, int_stall_r, int_stall_nxt;
  logic        bus_away;

  always_comb begin
    show_nxt      = SHOW_FIELD_WE ? SHOW_FIELD_WDATA : show_r;
    bus_away      = granted_r;
    halted_nxt    = halted_r;
    addr_nxt      = addr_r;
    fc_nxt        = fc_r;
    siz_nxt       = siz_r;
    rw_nxt        = rw_r;
    as_nxt        = 1'b0;
    ds_nxt        = 1'b0;
    dout_nxt      = dout_r;
    doe_nxt       = 1'b0;
    // Halt stops only after the current acknowledge has gone away
    if (halt_s && !bus_error_in_s && !tack_s && !CYCLE_ACTIVE)
      halted_nxt = 1'b1;
    else if (!halt_s)
      halted_nxt = 1'b0;
    // Halt never stalls internal cycles; program keeps running inside
    ext_stall_nxt = halted_nxt | bus_away | (run_r == RUN_DBLFAULT);
    int_stall_nxt = (show_r == `SHOW_ON_SUSPEND) && bus_away;
    // Held values return when bus regained with halt still asserted
    coe_nxt = !bus_away;
    if (CYCLE_ACTIVE && !halted_r && !bus_away) begin
      addr_nxt = CYCLE_ADDR;
      fc_nxt   = CYCLE_FC;
      siz_nxt  = CYCLE_SIZE;
      rw_nxt   = !CYCLE_WRITE;
      if (CYCLE_INTERNAL) begin
        if (show_r != `SHOW_OFF) begin
          ds_nxt   = 1'b1;
          dout_nxt = lane_data(CYCLE_SIZE, CYCLE_WDATA, 1'b1);
          doe_nxt  = 1'b1;
        end
      end else begin
        as_nxt = 1'b1;
        ds_nxt = 1'b1;
        if (CYCLE_WRITE) begin
          dout_nxt = lane_data(CYCLE_SIZE, CYCLE_WDATA, 1'b0);
          doe_nxt  = 1'b1;
        end
      end
    end
    if (halted_r) begin
      as_nxt  = 1'b0;
      ds_nxt  = 1'b0;
      doe_nxt = 1'b0;
    end
  end

  always_ff @(posedge CLK) begin
    if (RST) begin
      core_rst_r   <= 1'b1;
      run_r        <= RUN_POSTRST;
      bus_error_in_latch_r <= 1'b0;
      bus_error_in_exc_r   <= 1'b0;
      cyc_err_r    <= 1'b0;
      rdata_r      <= 16'h0000;
      rvalid_r     <= 1'b0;
      arb_r        <= ARB_IDLE;
      arb_cnt_r    <= 3'h0;
      grant_r      <= 1'b0;
      granted_r    <= 1'b0;
      show_r       <= `SHOW_FIELD_RESET;
      halted_r     <= 1'b0;
      addr_r       <= 24'h000000;
      fc_r         <= 3'h0;
      siz_r        <= 2'h0;
      rw_r         <= 1'b1;
      as_r         <= 1'b0;
      ds_r         <= 1'b0;
      dout_r       <= 16'h0000;
      doe_r        <= 1'b0;
      coe_r        <= 1'b1;
      ext_stall_r  <= 1'b0;
      int_stall_r  <= 1'b0;
    end else begin
      core_rst_r   <= core_rst_nxt;
      run_r        <= core_rst_nxt ? RUN_POSTRST : run_nxt;
      bus_error_in_latch_r <= core_rst_nxt ? 1'b0 : bus_error_in_latch_nxt;
      bus_error_in_exc_r   <= bus_error_in_exc_nxt;
      cyc_err_r    <= cyc_err_nxt;
      rdata_r      <= rdata_nxt;
      rvalid_r     <= rvalid_nxt;
      arb_r        <= arb_nxt;
      arb_cnt_r    <= arb_cnt_nxt;
      grant_r      <= grant_nxt;
      granted_r    <= granted_nxt;
      show_r       <= core_rst_nxt ? `SHOW_FIELD_RESET : show_nxt;
      halted_r     <= halted_nxt;
      addr_r       <= addr_nxt;
      fc_r         <= fc_nxt;
      siz_r        <= siz_nxt;
      rw_r         <= rw_nxt;
      as_r         <= as_nxt;
      ds_r         <= ds_nxt;
      dout_r       <= dout_nxt;
      doe_r        <= doe_nxt;
      coe_r        <= coe_nxt;
      ext_stall_r  <= ext_stall_nxt;
      int_stall_r  <= int_stall_nxt;
    end
  end

  // Outputs, all straight from flip-flops
  assign BUS_GRANT_N       = ~grant_r;
  // Bit 3 of the one-hot run state is the double fault flop itself
  assign HALT_OUT_N        = ~run_r[3];
  assign HALT_OUT_OE       = run_r[3];
  assign ADDR_OUT          = addr_r;
  assign FC_OUT            = fc_r;
  assign TRANSFER_SIZE_OUT = siz_r;
  assign RW_OUT            = rw_r;
  assign CTRL_OE           = coe_r;
  assign ADDRESS_STROBE_N  = ~as_r;
  assign DATA_STROBE_N     = ~ds_r;
  assign DATA_OUT          = dout_r;
  assign DATA_OE           = doe_r;
  assign READ_DATA         = rdata_r;
  assign READ_VALID        = rvalid_r;
  assign BUS_ERROR_IN_EXCEPTION    = bus_error_in_exc_r;
  assign DOUBLE_FAULT      = run_r[3];
  assign EXT_STALL         = ext_stall_r;
  assign INT_STALL         = int_stall_r;
  assign IRQ_BLOCK         = halted_r;
  assign CORE_RESET        = core_rst_r;
endmodule : ext_bus_fault_halt_arbitration

// ==== test/ext_bus_checker.sv ====
// Purpose: concurrent checks on the fault, halt and arbitration block
// Assumes: pins active low; outputs registered; one clock
// Notes:   sees only top-level ports; bound at the foot of this file
`timescale 1ns/100ps
module ext_bus_checker (
  input wire logic CLK,
  input wire logic RST,
  input wire logic BUS_REQUEST_N,
  input wire logic GRANT_ACKNOWLEDGE_N,
  input wire logic INSTR_DONE,
  input wire logic OPERAND_DONE,
  input wire logic CYCLE_ACTIVE,
  input wire logic CYCLE_INTERNAL,
  input wire logic BUS_GRANT_N,
  input wire logic HALT_OUT_N,
  input wire logic HALT_OUT_OE,
  input wire logic CTRL_OE,
  input wire logic ADDRESS_STROBE_N,
  input wire logic DATA_STROBE_N,
  input wire logic DATA_OE,
  input wire logic BUS_ERROR_IN_EXCEPTION,
  input wire logic DOUBLE_FAULT,
  input wire logic IRQ_BLOCK,
  input wire logic CORE_RESET
);
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (RST);
  // Five samples just cover the synchroniser plus granted_r and coe_r, with no cycle to spare
  sequence s_ack_held;
    !GRANT_ACKNOWLEDGE_N [*5];
  endsequence
  sequence s_grant_back;
    ##[1:10] BUS_GRANT_N;
  endsequence
  property p_df_hold;
    DOUBLE_FAULT |=> DOUBLE_FAULT || CORE_RESET;
  endproperty
  property p_df_pin;
    DOUBLE_FAULT |-> HALT_OUT_OE && !HALT_OUT_N;
  endproperty
  property p_exc_cause;
    BUS_ERROR_IN_EXCEPTION |-> $past(INSTR_DONE) && !$past(BUS_ERROR_IN_EXCEPTION);
  endproperty
  property p_grant_req;
    $fell(BUS_GRANT_N) |-> !$past(BUS_REQUEST_N, 2) || !$past(BUS_REQUEST_N, 3);
  endproperty
  property p_grant_operand;
    $fell(BUS_GRANT_N) |-> $past(OPERAND_DONE) || !$past(CYCLE_ACTIVE);
  endproperty
  property p_grant_drop;
    $fell(GRANT_ACKNOWLEDGE_N) |-> s_grant_back;
  endproperty
  property p_ctl_float;
    s_ack_held |-> !CTRL_OE;
  endproperty
  property p_show_as;
    !ADDRESS_STROBE_N |-> !$past(CYCLE_INTERNAL);
  endproperty
  property p_halt_quiet;
    IRQ_BLOCK && !CYCLE_ACTIVE && !$past(CYCLE_ACTIVE) |->
      ADDRESS_STROBE_N && DATA_STROBE_N && !DATA_OE;
  endproperty
  property p_rst_defaults;
    disable iff (1'b0)
    RST |=> BUS_GRANT_N && ADDRESS_STROBE_N && DATA_STROBE_N && !DATA_OE && !DOUBLE_FAULT;
  endproperty
  a_df_hold: assert property (p_df_hold) else $error("fault state left without reset");
  a_df_pin: assert property (p_df_pin) else $error("halt pin not driven low");
  a_exc_cause: assert property (p_exc_cause) else $error("exception not after instruction");
  a_grant_req: assert property (p_grant_req) else $error("grant without request");
  a_grant_operand: assert property (p_grant_operand) else $error("grant mid operand");
  a_grant_drop: assert property (p_grant_drop) else $error("grant kept after ack");
  a_ctl_float: assert property (p_ctl_float) else $error("control driven while owned");
  a_show_as: assert property (p_show_as) else $error("address strobe on internal");
  a_halt_quiet: assert property (p_halt_quiet) else $error("bus active while halted");
  a_rst_defaults: assert property (p_rst_defaults) else $error("bad reset outputs");
endmodule : ext_bus_checker
bind ext_bus_fault_halt_arbitration ext_bus_checker u_chk (.*);

// ==== test/ext_master.sv ====
// Purpose: external bus master that requests, takes and gives back the bus
// Assumes: single requester, so no outside priority logic
// Notes:   pins change on the rising edge only
`timescale 1ns/100ps
module ext_master #(
  parameter int OWN_CYCLES = 6
) (
  input  wire logic CLK,
  input  wire logic RST,
  input  wire logic WANT,
  input  wire logic BUS_GRANT_N,
  output logic      BUS_REQUEST_N,
  output logic      GRANT_ACKNOWLEDGE_N
);
  int cnt_r = 0;
  always @(posedge CLK) begin
    if (RST) begin
      BUS_REQUEST_N <= 1'b1;
      GRANT_ACKNOWLEDGE_N <= 1'b1;
    end else if (!GRANT_ACKNOWLEDGE_N) begin
      cnt_r <= cnt_r + 1;
      if (cnt_r == OWN_CYCLES - 1) GRANT_ACKNOWLEDGE_N <= 1'b1;
    end else if (!BUS_REQUEST_N && !BUS_GRANT_N) begin
      // Only with a grant and no owner; request drops as ownership starts
      GRANT_ACKNOWLEDGE_N <= 1'b0;
      BUS_REQUEST_N <= 1'b1;
      cnt_r <= 0;
    end else if (WANT) begin
      BUS_REQUEST_N <= 1'b0;
    end
  end
endmodule : ext_master

// ==== test/tb_top.sv ====
// Purpose: directed bench for the fault, halt and arbitration block
// Assumes: inputs change 1 ns after the rising edge
// Notes:   a monitor counts output events between clears
`timescale 1ns/100ps
module tb_top;
  logic CLK, RST, RESET_PIN_N, BUS_REQUEST_N, GRANT_ACKNOWLEDGE_N, BUS_ERROR_IN_N, HALT_IN_N;
  logic TRANSFER_ACK_N, CYCLE_ACTIVE, CYCLE_END, CYCLE_INTERNAL, CYCLE_WRITE, CYCLE_PREFETCH;
  logic OPERAND_DONE, WRITE_PENDING, INSTR_DONE, HANDLER_FIRST, FIRST_AFTER_RESET, SHOW_FIELD_WE;
  logic BUS_GRANT_N, HALT_OUT_N, HALT_OUT_OE, RW_OUT, CTRL_OE, ADDRESS_STROBE_N, DATA_STROBE_N;
  logic DATA_OE, READ_VALID, BUS_ERROR_IN_EXCEPTION, DOUBLE_FAULT, EXT_STALL, INT_STALL, IRQ_BLOCK;
  logic CORE_RESET, want;
  logic [23:0] CYCLE_ADDR, ADDR_OUT;
  logic [15:0] CYCLE_WDATA, DATA_PIN_IN, DATA_OUT, READ_DATA, rd_q, dq;
  logic [2:0]  CYCLE_FC, FC_OUT;
  logic [1:0]  CYCLE_SIZE, SHOW_FIELD_WDATA, TRANSFER_SIZE_OUT;
  int err_total, checks, n_exc, n_ds, n_as, n_bg, n_ctl, n_ist, n_oe;
  ext_bus_fault_halt_arbitration u_dut (.*);
  ext_master u_master (.CLK(CLK), .RST(RST), .WANT(want), .BUS_GRANT_N(BUS_GRANT_N),
    .BUS_REQUEST_N(BUS_REQUEST_N), .GRANT_ACKNOWLEDGE_N(GRANT_ACKNOWLEDGE_N));
  initial begin
    CLK = 1'b0;
    forever #5 CLK = ~CLK;
  end
  always @(posedge CLK) begin
    if (BUS_ERROR_IN_EXCEPTION === 1'b1) n_exc++;
    if (DATA_STROBE_N === 1'b0) n_ds++;
    if (ADDRESS_STROBE_N === 1'b0) n_as++;
    if (BUS_GRANT_N === 1'b0) n_bg++;
    if (CTRL_OE === 1'b0) n_ctl++;
    if (INT_STALL === 1'b1) n_ist++;
    if (DATA_OE === 1'b1) n_oe++;
    if (READ_VALID === 1'b1) rd_q = READ_DATA;
    if (DATA_OE === 1'b1) dq = DATA_OUT;
  end
  task tick(input int n);
    repeat (n) @(posedge CLK);
    #1;
  endtask : tick
  task clr;
    {n_exc, n_ds, n_as, n_bg, n_ctl, n_ist, n_oe} = '0;
  endtask : clr
  task chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      err_total++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task cpu(input logic [2:0] p);
    {INSTR_DONE, HANDLER_FIRST, FIRST_AFTER_RESET} = p;
    tick(1);
    {INSTR_DONE, HANDLER_FIRST, FIRST_AFTER_RESET} = 3'h0;
    tick(2);
  endtask : cpu
  task cyc(input logic intl, wr, pf, err, input logic [1:0] sz, input logic [15:0] d);
    {CYCLE_INTERNAL, CYCLE_WRITE, CYCLE_PREFETCH, CYCLE_SIZE} = {intl, wr, pf, sz};
    {CYCLE_WDATA, DATA_PIN_IN, CYCLE_ADDR, CYCLE_FC} = {d, d, 8'h3C, d, 3'h5};
    {CYCLE_ACTIVE, BUS_ERROR_IN_N, TRANSFER_ACK_N} = {1'b1, ~err, err};
    // Error pin leads cycle end by three cycles, one more than the synchroniser depth
    tick(3);
    {CYCLE_END, OPERAND_DONE} = 2'h3;
    tick(1);
    {CYCLE_END, OPERAND_DONE, CYCLE_ACTIVE, BUS_ERROR_IN_N, TRANSFER_ACK_N} = 5'h03;
    // Released pins show the inverse so a late capture cannot pass
    DATA_PIN_IN = ~d;
    tick(4);
  endtask : cyc
  task shw(input logic [1:0] f);
    {SHOW_FIELD_WDATA, SHOW_FIELD_WE} = {f, 1'b1};
    tick(1);
    SHOW_FIELD_WE = 1'b0;
    tick(1);
  endtask : shw
  task arb(input logic [1:0] f);
    shw(f);
    clr;
    want = 1'b1;
    tick(1);
    want = 1'b0;
    tick(40);
    chk(n_bg != 0, 1'b1);
    chk(n_bg < 12, 1'b1);
    chk(n_ctl != 0, 1'b1);
    chk(n_ist != 0, f == 2'h2);
    chk(BUS_GRANT_N, 1'b1);
  endtask : arb
  task t_reset;
    RST = 1'b1;
    tick(5);
    RST = 1'b0;
    tick(3);
    chk({BUS_GRANT_N, ADDRESS_STROBE_N, DATA_STROBE_N, DATA_OE, CTRL_OE}, 5'h1D);
    clr;
    cyc(1, 1, 0, 0, 2'h2, 16'h4321);
    chk({n_ds != 0, n_oe != 0}, 2'h0);
    $display("test reset done");
  endtask : t_reset
  task t_post_df;
    cyc(0, 0, 0, 1, 2'h2, 16'h0BAD);
    chk({DOUBLE_FAULT, HALT_OUT_OE, HALT_OUT_N}, 3'h6);
    cpu(3'h7);
    chk(DOUBLE_FAULT, 1'b1);
    arb(2'h0);
    $display("test post reset fault done");
  endtask : t_post_df
  task t_reads;
    cpu(3'h1);
    clr;
    cyc(0, 0, 0, 0, 2'h2, 16'h1234);
    chk(rd_q, 16'h1234);
    cyc(0, 0, 0, 1, 2'h2, 16'h5678);
    chk(rd_q, 16'h1234);
    cyc(0, 0, 1, 1, 2'h2, 16'h5678);
    chk(rd_q, 16'hFFFF);
    chk({n_exc != 0, DOUBLE_FAULT}, 2'h0);
    cpu(3'h4);
    chk(n_exc == 1, 1'b1);
    $display("test reads done");
  endtask : t_reads
  task t_handler;
    cpu(3'h2);
    clr;
    cpu(3'h4);
    chk(n_exc == 0, 1'b1);
    cyc(0, 0, 0, 1, 2'h2, 16'h2222);
    chk(DOUBLE_FAULT, 1'b0);
    cpu(3'h4);
    chk(n_exc == 1, 1'b1);
    $display("test handler done");
  endtask : t_handler
  task t_halt;
    cyc(0, 1, 0, 0, 2'h2, 16'h2468);
    HALT_IN_N = 1'b0;
    clr;
    tick(6);
    chk(ADDR_OUT, 24'h3C2468);
    chk({FC_OUT, RW_OUT}, 4'hA);
    chk({ADDRESS_STROBE_N, DATA_STROBE_N, DATA_OE, IRQ_BLOCK, EXT_STALL}, 5'h1B);
    arb(2'h0);
    chk({ADDR_OUT, FC_OUT, RW_OUT, CTRL_OE}, 29'h7848D15);
    cyc(1, 0, 0, 0, 2'h2, 16'h1357);
    chk(n_ist == 0, 1'b1);
    chk(rd_q, 16'h1357);
    // Drop halt for good so the next external cycle runs
    HALT_IN_N = 1'b1;
    tick(6);
    clr;
    cyc(0, 0, 0, 0, 2'h2, 16'h3333);
    chk({IRQ_BLOCK, n_as != 0}, 2'h1);
    $display("test halt done");
  endtask : t_halt
  task t_show;
    logic [15:0] d;
    for (int f = 0; f < 4; f++) begin
      d = 16'hA5A0 + 16'(f);
      shw(f[1:0]);
      clr;
      cyc(1, 1, 0, 0, 2'h2, d);
      chk({n_ds != 0, n_oe != 0}, {2{f != 0}});
      chk(n_as == 0, 1'b1);
      if (f != 0) chk(dq, d);
    end
    cyc(0, 1, 0, 0, 2'h1, 16'h00C3);
    chk({dq, TRANSFER_SIZE_OUT}, 18'h30F0D);
    $display("test show done");
  endtask : t_show
  task t_arb;
    arb(2'h2);
    arb(2'h1);
    shw(2'h0);
    CYCLE_ACTIVE = 1'b1;
    want = 1'b1;
    tick(1);
    want = 1'b0;
    clr;
    tick(10);
    chk(n_bg == 0, 1'b1);
    OPERAND_DONE = 1'b1;
    tick(1);
    {OPERAND_DONE, CYCLE_ACTIVE} = 2'h0;
    tick(30);
    chk(n_bg != 0, 1'b1);
    $display("test arbitration done");
  endtask : t_arb
  task t_fault_pin;
    cyc(0, 0, 0, 1, 2'h2, 16'h4444);
    chk(DOUBLE_FAULT, 1'b1);
    // Reset must wait while a write is still in flight
    {WRITE_PENDING, RESET_PIN_N} = 2'h2;
    tick(8);
    chk({CORE_RESET, DOUBLE_FAULT}, 2'h1);
    WRITE_PENDING = 1'b0;
    tick(5);
    chk(CORE_RESET, 1'b1);
    RESET_PIN_N = 1'b1;
    tick(6);
    chk({CORE_RESET, DOUBLE_FAULT}, 2'h0);
    $display("test fault and pin reset done");
  endtask : t_fault_pin
  task complete_run;
    $display("checks %0d mismatches %0d", checks, err_total);
    if (err_total == 0 && checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : complete_run
  initial begin
    {RST, RESET_PIN_N, BUS_ERROR_IN_N, HALT_IN_N, TRANSFER_ACK_N} = 5'h1F;
    {CYCLE_ACTIVE, CYCLE_END, CYCLE_INTERNAL, CYCLE_WRITE, CYCLE_PREFETCH} = 5'h00;
    {OPERAND_DONE, WRITE_PENDING, INSTR_DONE, HANDLER_FIRST, FIRST_AFTER_RESET} = 5'h00;
    {CYCLE_ADDR, CYCLE_FC, CYCLE_SIZE, CYCLE_WDATA, DATA_PIN_IN} = '0;
    {SHOW_FIELD_WDATA, SHOW_FIELD_WE, want} = 4'h0;
    t_reset;
    t_post_df;
    t_reset;
    t_reads;
    t_handler;
    t_halt;
    t_show;
    t_arb;
    t_fault_pin;
    complete_run;
  end
  initial begin
    #60000;
    err_total++;
    complete_run;
  end
endmodule : tb_top
